// *** design/pscr_top.v ***
// Power sequence controller with its status, converter control and per-state registers.
`include "pscr_defines.vh"

// What this block does
// R01 - Status bits 29, 28, 25 and 24 show whether IO supply, PLL regulator, analogue and core converter were on in the previous state.
// R02 - After reset the previous-state bit of the analogue converter reads 1 and the other three read 0.
// R03 - Status bits 18:16 report the current state of the eight-state power sequence.
// R04 - The states are coded 0 to 7 in the order reset, asleep, waking 1, waking 2, awake wait, awake, sleeping 1, sleeping 2.
// R05 - Status bits 14, 5, 4, 1 and 0 show tile clock disable and the IO, PLL, analogue and core enables now applied, all reset to 0.
// R06 - Status bits 9 and 8 show analogue and core converter modulation, 0 for PWM and 1 for PFM, reset to 0.
// R07 - Control bits 25:24 choose the power-good threshold of both rails and reset to 2.
// R08 - Control bit 16 clears both converter error flags while set, stays set until software writes 0, and resets to 0.
// R09 - Control bits 14:13 set the analogue converter current limit and reset to 0.
// R10 - Control bits 9:8 choose the analogue converter switching clock and reset to 1.
// R11 - Control bits 6:5 set the core converter current limit and reset to 0.
// R12 - Control bits 1:0 choose the core converter switching clock and reset to 1.
// R13 - Reserved bits read as zero and ignore writes, and the whole status register ignores writes.
// R14 - Enables, modulation and tile clock gating applied in each state come from that state's configuration word, as reset or as software last wrote it.
module pscr_top #(
  parameter STEP_CYCLES = `PSCR_STEP_CYCLES
) (
  // AHB-Lite slave.
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Sequence requests and supply feedback from pins.
  input wire sleep_req,
  input wire wake_req,
  input wire power_good,
  input wire conv_error,
  // Applied supply settings.
  output reg core_converter_en,
  output reg analogue_converter_en,
  output reg pll_regulator_en,
  output reg io_supply_output_en,
  output reg core_converter_pfm,
  output reg analogue_converter_pfm,
  output reg tile_clk_disable,
  // Converter control.
  output reg [1:0] pg_level,
  output reg conv_err_clear,
  output reg [1:0] analogue_converter_ilim,
  output reg [1:0] analogue_converter_clk_sel,
  output reg [1:0] core_converter_ilim,
  output reg [1:0] core_converter_clk_sel,
  // Interrupt.
  output reg irq
);
  localparam ST_RESET = 3'd0;
  localparam ST_ASLEEP = 3'd1;
  localparam ST_WAKING1 = 3'd2;
  localparam ST_WAKING2 = 3'd3;
  localparam ST_AWAKE_WAIT = 3'd4;
  localparam ST_AWAKE = 3'd5;
  localparam ST_SLEEPING1 = 3'd6;
  localparam ST_SLEEPING2 = 3'd7;
  localparam [31:0] STEP_LAST_W = STEP_CYCLES - 1;
  localparam [15:0] STEP_LAST = STEP_LAST_W[15:0];

  reg [11:0] addr_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] dwell_q;
  reg [3:0] prev_q;
  reg [31:0] ctrl_q;
  reg [1:0] ists_q;
  reg [1:0] imask_q;
  reg err_flag_q;
  reg err_s_q;
  reg [31:0] rdata_d;
  reg cfg_fwd_q;
  reg [14:0] cfg_fwd_data_q;
  wire [3:0] pins_s;
  wire [14:0] cfg_rd_a;
  wire [14:0] cfg_rd_b;
  wire addr_take;
  wire step_done;
  wire state_change;
  wire [1:0] events;
  wire [31:0] status_word;
  wire [14:0] cfg_wdata;
  wire [14:0] cfg_word;

  function is_cfg;
    input [11:0] a;
    begin
      is_cfg = (a >= `PSCR_OFS_CFG_BASE) && (a <= `PSCR_OFS_CFG_LAST) && (a[1:0] == 2'b00);
    end
  endfunction

  pscr_sync #(
    .WIDTH(4)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({conv_error, power_good, wake_req, sleep_req}),
    .sync_out(pins_s)
  );

  assign cfg_wdata = hwdata[14:0] & `PSCR_CFG_WMASK; // [R13]

  pscr_cfg_mem #(
    .WIDTH(15),
    .DEPTH(8),
    .AW(3)
  ) u_cfg (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pend_q && is_cfg(addr_q)),
    .wr_addr(addr_q[4:2]),
    .wr_data(cfg_wdata),
    .rd_addr_a(haddr[4:2]),
    .rd_data_a(cfg_rd_a),
    .rd_addr_b(state_q),
    .rd_data_b(cfg_rd_b)
  );

  // Every nonsequential or sequential transfer is decoded as a whole-word access; hsize is not checked.
  assign addr_take = hsel && htrans[1] && hready;

  // Bus phases: writes complete with no wait, reads take one wait state.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 12'h000;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_take && hwrite;
      rd_pend_q <= addr_take && !hwrite;
      if (addr_take) begin
        addr_q <= haddr[11:0];
      end
      hreadyout <= !(addr_take && !hwrite);
      if (rd_pend_q) begin
        hrdata <= rdata_d;
      end
    end
  end

  // A read taken in the cycle in which a configuration write lands would fetch the old word.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_fwd_q <= 1'b0;
      cfg_fwd_data_q <= 15'h0000;
    end else begin
      cfg_fwd_q <= addr_take && !hwrite && wr_pend_q && is_cfg(addr_q) &&
        (haddr[11:0] == addr_q);
      cfg_fwd_data_q <= cfg_wdata;
    end
  end

  assign cfg_word = cfg_fwd_q ? cfg_fwd_data_q : cfg_rd_a;

  assign status_word = {2'b00, prev_q[3], prev_q[2], 2'b00, prev_q[1], prev_q[0], // [R01]
    5'h00, state_q, // [R03]
    1'b0, tile_clk_disable, 4'h0, analogue_converter_pfm, core_converter_pfm, // [R06]
    2'b00, io_supply_output_en, pll_regulator_en, 2'b00,
    analogue_converter_en, core_converter_en}; // [R05]

  // Unmapped addresses read as zero; reserved bits are masked out on write.
  always @* begin
    rdata_d = 32'h0000_0000;
    if (is_cfg(addr_q)) begin
      rdata_d = {17'h00000, cfg_word};
    end else begin
      case (addr_q)
        `PSCR_OFS_SEQ_STATUS: rdata_d = status_word;
        `PSCR_OFS_CONV_CTRL: rdata_d = ctrl_q;
        `PSCR_OFS_INT_STATUS: rdata_d = {30'h0000_0000, ists_q};
        `PSCR_OFS_INT_MASK: rdata_d = {30'h0000_0000, imask_q};
        `PSCR_OFS_CONV_ERR: rdata_d = {31'h0000_0000, err_flag_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Writable registers; the status register has no write path at all.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PSCR_CTRL_RST; // [R07] [R10] [R12]
      imask_q <= 2'b00;
    end else if (wr_pend_q) begin
      if (addr_q == `PSCR_OFS_CONV_CTRL) begin
        ctrl_q <= hwdata & `PSCR_CTRL_WMASK; // [R13]
      end
      if (addr_q == `PSCR_OFS_INT_MASK) begin
        imask_q <= hwdata[1:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_level <= 2'b10;
      conv_err_clear <= 1'b0;
      analogue_converter_ilim <= 2'b00;
      analogue_converter_clk_sel <= 2'b01;
      core_converter_ilim <= 2'b00;
      core_converter_clk_sel <= 2'b01;
    end else begin
      pg_level <= ctrl_q[`PSCR_PG_HI:`PSCR_PG_LO]; // [R07]
      conv_err_clear <= ctrl_q[`PSCR_BIT_ERR_CLR]; // [R08]
      analogue_converter_ilim <= ctrl_q[`PSCR_ANA_ILIM_HI:`PSCR_ANA_ILIM_LO]; // [R09]
      analogue_converter_clk_sel <= ctrl_q[`PSCR_ANA_CLK_HI:`PSCR_ANA_CLK_LO]; // [R10]
      core_converter_ilim <= ctrl_q[`PSCR_CORE_ILIM_HI:`PSCR_CORE_ILIM_LO]; // [R11]
      core_converter_clk_sel <= ctrl_q[`PSCR_CORE_CLK_HI:`PSCR_CORE_CLK_LO]; // [R12]
    end
  end

  assign step_done = (dwell_q == STEP_LAST);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: if (step_done) state_d = ST_WAKING1;
      ST_ASLEEP: if (pins_s[1]) state_d = ST_WAKING1;
      ST_WAKING1: if (step_done) state_d = ST_WAKING2;
      ST_WAKING2: if (step_done) state_d = ST_AWAKE_WAIT;
      ST_AWAKE_WAIT: if (pins_s[2]) state_d = ST_AWAKE;
      ST_AWAKE: if (pins_s[0]) state_d = ST_SLEEPING1;
      ST_SLEEPING1: if (step_done) state_d = ST_SLEEPING2;
      ST_SLEEPING2: if (step_done) state_d = ST_ASLEEP;
      default: state_d = ST_RESET;
    endcase
  end

  assign state_change = (state_d != state_q);

  // Sequencer with a fixed dwell in every timed state.
  // Requests are levels, so one held early acts as soon as its state is reached.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_RESET; // [R04]
      dwell_q <= 16'h0000;
      prev_q <= `PSCR_PREV_RST; // [R02]
    end else begin
      state_q <= state_d; // [R03]
      if (state_change) begin
        dwell_q <= 16'h0000;
        // Applied settings lag the state by two cycles, so these are still the old state's.
        prev_q <= {io_supply_output_en, pll_regulator_en,
          analogue_converter_en, core_converter_en}; // [R01]
      end else if (!step_done) begin
        dwell_q <= dwell_q + 16'h0001;
      end
    end
  end

  // Applied settings follow the configuration of the present state, edits included.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_converter_en <= 1'b0;
      analogue_converter_en <= 1'b0;
      pll_regulator_en <= 1'b0;
      io_supply_output_en <= 1'b0;
      core_converter_pfm <= 1'b0;
      analogue_converter_pfm <= 1'b0;
      tile_clk_disable <= 1'b0;
    end else begin
      core_converter_en <= cfg_rd_b[`PSCR_BIT_EN_CORE]; // [R14] [R05]
      analogue_converter_en <= cfg_rd_b[`PSCR_BIT_EN_ANA]; // [R14]
      pll_regulator_en <= cfg_rd_b[`PSCR_BIT_EN_PLL]; // [R14]
      io_supply_output_en <= cfg_rd_b[`PSCR_BIT_EN_IO]; // [R14]
      core_converter_pfm <= cfg_rd_b[`PSCR_BIT_MOD_CORE]; // [R14] [R06]
      analogue_converter_pfm <= cfg_rd_b[`PSCR_BIT_MOD_ANA]; // [R14] [R06]
      tile_clk_disable <= cfg_rd_b[`PSCR_BIT_TILE_DIS]; // [R14]
    end
  end

  assign events = {pins_s[3] && !err_s_q, state_change};

  // Error flag and interrupt status: a new event always wins over a clear.
  // The interrupt leaves a flip-flop and so trails the status by one cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_s_q <= 1'b0;
      err_flag_q <= 1'b0;
      ists_q <= 2'b00;
      irq <= 1'b0;
    end else begin
      err_s_q <= pins_s[3];
      err_flag_q <= pins_s[3] || (err_flag_q && !ctrl_q[`PSCR_BIT_ERR_CLR]); // [R08]
      if (wr_pend_q && (addr_q == `PSCR_OFS_INT_STATUS)) begin
        ists_q <= (ists_q & ~hwdata[1:0]) | events;
      end else begin
        ists_q <= ists_q | events;
      end
      irq <= |(ists_q & imask_q);
    end
  end
endmodule

// *** design/pscr_defines.vh ***
// Register map, field positions and reset values of the power sequence register block.
`ifndef PSCR_DEFINES_VH
`define PSCR_DEFINES_VH

`define PSCR_OFS_SEQ_STATUS 12'h024
`define PSCR_OFS_CONV_CTRL 12'h02C
`define PSCR_OFS_INT_STATUS 12'h050
`define PSCR_OFS_INT_MASK 12'h054
`define PSCR_OFS_CONV_ERR 12'h058
`define PSCR_OFS_CFG_BASE 12'h100
`define PSCR_OFS_CFG_LAST 12'h11C

`define PSCR_BIT_PREV_IO 29
`define PSCR_BIT_PREV_PLL 28
`define PSCR_BIT_PREV_ANA 25
`define PSCR_BIT_PREV_CORE 24
`define PSCR_STATE_HI 18
`define PSCR_STATE_LO 16
`define PSCR_BIT_TILE_DIS 14
`define PSCR_BIT_MOD_ANA 9
`define PSCR_BIT_MOD_CORE 8
`define PSCR_BIT_EN_IO 5
`define PSCR_BIT_EN_PLL 4
`define PSCR_BIT_EN_ANA 1
`define PSCR_BIT_EN_CORE 0

`define PSCR_PG_HI 25
`define PSCR_PG_LO 24
`define PSCR_BIT_ERR_CLR 16
`define PSCR_ANA_ILIM_HI 14
`define PSCR_ANA_ILIM_LO 13
`define PSCR_ANA_CLK_HI 9
`define PSCR_ANA_CLK_LO 8
`define PSCR_CORE_ILIM_HI 6
`define PSCR_CORE_ILIM_LO 5
`define PSCR_CORE_CLK_HI 1
`define PSCR_CORE_CLK_LO 0

`define PSCR_CTRL_WMASK 32'h0301_6363
`define PSCR_CTRL_RST 32'h0200_0101
`define PSCR_CFG_WMASK 15'h4333
`define PSCR_CFG_RST 15'h0033
`define PSCR_PREV_RST 4'h2

`define PSCR_INT_STATE 0
`define PSCR_INT_ERR 1

`define PSCR_STEP_CYCLES 16
`endif

// *** design/pscr_sync.v ***
// Three-stage input synchroniser whose output flop accepts a change once the last two stages agree.
module pscr_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Asynchronous inputs and their filtered copies.
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // A lone glitch in the second stage never reaches the output.
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate
endmodule

// *** design/pscr_cfg_mem.v ***
// Per-state configuration store with one write port and two registered read ports.
`include "pscr_defines.vh"
module pscr_cfg_mem #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Write port.
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port for the bus.
  input wire [AW-1:0] rd_addr_a,
  output reg [WIDTH-1:0] rd_data_a,
  // Read port for the sequencer.
  input wire [AW-1:0] rd_addr_b,
  output reg [WIDTH-1:0] rd_data_b
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  integer k;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_q[k] <= `PSCR_CFG_RST;
      end
      rd_data_a <= {WIDTH{1'b0}};
      rd_data_b <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_a <= mem_q[rd_addr_a];
      rd_data_b <= mem_q[rd_addr_b];
    end
  end
endmodule

// *** verif/pscr_monitor.sv ***
// Checker of bus timing and converter control outputs of the power sequence register block.
module pscr_monitor #(
  parameter STEP_CYCLES = 16
) (
  // Bus side.
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Converter control outputs.
  input wire [1:0] pg_level,
  input wire conv_err_clear,
  input wire [1:0] analogue_converter_ilim,
  input wire [1:0] analogue_converter_clk_sel,
  input wire [1:0] core_converter_ilim,
  input wire [1:0] core_converter_clk_sel
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc = hsel && htrans[1] && hready;
  wire cw = acc && hwrite && haddr[11:0] == 12'h02C;
  wire rs = acc && !hwrite;
  // The outputs mirror the register one cycle late, so they are rebuilt in register layout.
  wire [31:0] ctl = {6'h0, pg_level, 7'h0, conv_err_clear, 1'b0, analogue_converter_ilim, 3'h0,
    analogue_converter_clk_sel, 1'b0, core_converter_ilim, 3'h0, core_converter_clk_sel};
  a_ctrl_reset: assert property ($rose(hresetn) |-> ctl == 32'h0200_0101)
    else $error("control outputs not at reset values");
  a_ctrl_write: assert property (cw ##1 1'b1 |-> ##2 ctl == ($past(hwdata, 2) & 32'h0301_6363))
    else $error("control outputs differ from written word");
  a_ctrl_hold: assert property ($changed(ctl) |-> $past(cw, 3))
    else $error("control outputs changed without a write");
  a_read_wait: assert property (rs |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_zero: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  a_stat_rsvd: assert property (rs && haddr[11:0] == 12'h024 |-> ##2 (hrdata & 32'hCCF8_BCCC) == 0)
    else $error("status reserved bits set");
  a_ctrl_rsvd: assert property (rs && haddr[11:0] == 12'h02C |-> ##2 hrdata == ctl)
    else $error("control read differs from outputs");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  cover property (cw);
  cover property (rs && haddr[11:0] == 12'h024);
  cover property ($rose(conv_err_clear));
endmodule

bind pscr_top pscr_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_pscr_monitor (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pg_level(pg_level), .conv_err_clear(conv_err_clear),
  .analogue_converter_ilim(analogue_converter_ilim),
  .analogue_converter_clk_sel(analogue_converter_clk_sel),
  .core_converter_ilim(core_converter_ilim), .core_converter_clk_sel(core_converter_clk_sel));

// *** verif/tb_pscr_top.sv ***
// Self-checking bench of the power sequence register block.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch %0t: %h not %h", $time, a, b); end end
module tb_pscr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic sleep_req = 0, wake_req = 0, power_good = 0, conv_error = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, keep;
  logic [1:0] htrans = 0, pg_level, ailim, aclk, cilim, cclk;
  logic hreadyout, hresp, irq, conv_err_clear;
  logic [6:0] app;
  int error_cnt = 0, checks = 0;
  logic [31:0] wd [5] = '{32'hFFFF_FFFF, 32'h0, 32'h0100_2121, 32'h0200_4242, 32'h0300_6363};
  logic [31:0] ex [5] = '{32'h0301_6363, 32'h0, 32'h0100_2121, 32'h0200_4242, 32'h0300_6363};
  wire [31:0] ctl = {6'h0, pg_level, 7'h0, conv_err_clear, 1'b0, ailim, 3'h0, aclk, 1'b0, cilim,
    3'h0, cclk};
  // A short step keeps the timed states brief; expectations do not depend on its value.
  pscr_top #(.STEP_CYCLES(8)) u_pscr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_req(sleep_req), .wake_req(wake_req), .power_good(power_good),
    .conv_error(conv_error), .core_converter_en(app[0]), .analogue_converter_en(app[1]),
    .pll_regulator_en(app[2]), .io_supply_output_en(app[3]), .core_converter_pfm(app[4]),
    .analogue_converter_pfm(app[5]), .tile_clk_disable(app[6]), .pg_level(pg_level),
    .conv_err_clear(conv_err_clear), .analogue_converter_ilim(ailim),
    .analogue_converter_clk_sel(aclk), .core_converter_ilim(cilim),
    .core_converter_clk_sel(cclk), .irq(irq));
  always #5 hclk = ~hclk;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 60; i++) begin
      xfer(0, 12'h024, 0);
      if (r[18:16] === s) break;
    end
    `CHK(r[18:16], s)
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK({app, irq, hreadyout, hresp}, 10'h002)
    `CHK(ctl, 32'h0200_0101)
    hresetn <= 1'b1;
    xfer(0, 12'h024, 0);
    `CHK(r & 32'h3307_0000, 32'h0200_0000)
    xfer(0, 12'h02C, 0);
    `CHK(r, 32'h0200_0101)
    $display("reset test done");
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    stop_test();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 5; i++) begin
      xfer(1, 12'h02C, wd[i]);
      xfer(0, 12'h02C, 0);
      `CHK(r, ex[i])
      `CHK(ctl, ex[i])
    end
    xfer(0, 12'h0F0, 0);
    `CHK(r, 32'h0)
    $display("control test done");
    xfer(1, 12'h104, 32'h0000_4302);
    xfer(1, 12'h108, 32'hFFFF_FFFF);
    xfer(0, 12'h108, 0);
    `CHK(r, 32'h0000_4333)
    wait_state(3'h4);
    power_good <= 1'b1;
    wait_state(3'h5);
    `CHK(r & 32'h3300_0033, 32'h3300_0033)
    `CHK(app, 7'h0F)
    sleep_req <= 1'b1;
    wait_state(3'h1);
    sleep_req <= 1'b0;
    xfer(0, 12'h024, 0);
    keep = r;
    `CHK(r & 32'h3300_7FFF, 32'h3300_4302)
    `CHK(app, 7'h72)
    xfer(1, 12'h024, 32'hFFFF_FFFF);
    xfer(0, 12'h024, 0);
    `CHK(r, keep)
    $display("sequence test done");
    xfer(1, 12'h054, 32'h1);
    xfer(0, 12'h050, 0);
    `CHK({irq, r[0]}, 2'h3)
    xfer(1, 12'h050, 32'h1);
    xfer(0, 12'h050, 0);
    `CHK({irq, r[1:0]}, 3'h0)
    conv_error <= 1'b1;
    repeat (8) @(posedge hclk);
    xfer(0, 12'h050, 0);
    `CHK({irq, r[1:0]}, 3'h2)
    xfer(1, 12'h054, 32'h3);
    xfer(0, 12'h058, 0);
    `CHK({irq, r[0]}, 2'h3)
    conv_error <= 1'b0;
    repeat (8) @(posedge hclk);
    xfer(0, 12'h058, 0);
    `CHK(r[0], 1'b1)
    xfer(1, 12'h02C, 32'h0201_0101);
    xfer(0, 12'h058, 0);
    `CHK(r[0], 1'b0)
    xfer(0, 12'h02C, 0);
    `CHK({conv_err_clear, r}, {1'b1, 32'h0201_0101})
    $display("interrupt test done");
    do_reset();
    stop_test();
  end
endmodule
